// File: hw/rsf_consts.svh
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH

// Geometry
`define RSF_NUM_RODS     61
`define RSF_NUM_GRP      8
`define RSF_NUM_SAFETY   4
`define RSF_NUM_METERS   4
`define RSF_NUM_REG      3
`define RSF_POS_W        8
`define RSF_GRP_W        3
`define RSF_CNT_W        6
`define RSF_SUM_W        14
`define RSF_NUM_SW       6

// Regulating group indices (groups 5, 6, 7)
`define RSF_G5           3'h4
`define RSF_G6           3'h5
`define RSF_G7           3'h6
`define RSF_REG_BASE     4

// One position count is one inch, full scale 139
`define RSF_POS_RST      8'h00
// Strict greater-than setpoints: above 103 means at or above 75%
`define RSF_SEQ_HI_SP    8'h67
// Not above 35 means at or below 25%
`define RSF_SEQ_LO_SP    8'h23
// Asymmetry setpoints, 7 and 9 inches
`define RSF_ASY_ALARM_SP 8'h07
`define RSF_ASY_FAULT_SP 8'h09

`endif

// File: hw/rsf_pkg.sv
`include "rsf_consts.svh"

package rsf_pkg;

    typedef logic [`RSF_POS_W-1:0] rsf_pos_t;
    typedef logic [`RSF_GRP_W-1:0] rsf_grp_t;

    typedef struct packed {
        logic auto_sel;
        logic bypass_sel;
        logic fault_clear;
        logic pwr_above_60;
        logic rel_disp_sel;
        logic meter_hi_sel;
    } rsf_switch_t;

    typedef struct packed {
        logic full_in;
        logic full_out;
        logic enabled;
    } rsf_grp_ind_t;

    typedef struct packed {
        logic full_out;
        logic full_in;
        logic enabled;
        logic xfer;
        logic asym;
    } rsf_rod_ind_t;

    typedef struct packed {
        logic asym_alarm;
        logic asym_fault;
        logic out_inhibit;
        logic seq_fault;
        logic safety_alarm;
        logic bypass_ind;
        logic aux_permit;
        logic auto_mode;
    } rsf_alarm_t;

endpackage : rsf_pkg

// File: hw/rsf_asym_mon.sv
`timescale 1ns/1ps

module rsf_asym_mon
    import rsf_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     nrst_i,
    input  wire rsf_pos_t rod_pos_i,
    input  wire rsf_pos_t grp_avg_i,
    input  wire logic     clear_i,
    output logic          alarm_o,
    output logic          fault_o
);

    rsf_pos_t diff;
    logic     alarm_ff;
    logic     fault_ff;

    assign diff = (rod_pos_i > grp_avg_i) ? rod_pos_i - grp_avg_i
                                          : grp_avg_i - rod_pos_i;

    // latched 7-inch alarm, set beats clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_ff <= 1'b0;
        end else if (diff > `RSF_ASY_ALARM_SP) begin
            alarm_ff <= 1'b1;
        end else if (clear_i) begin
            alarm_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= diff > `RSF_ASY_FAULT_SP;
        end
    end

    assign alarm_o = alarm_ff;
    assign fault_o = fault_ff;

    property p_asym_set;
        @(posedge clk_i) disable iff (!nrst_i)
        (diff > `RSF_ASY_ALARM_SP) |=> alarm_ff;
    endproperty
    a_asym_set: assert property (p_asym_set)
        else $error("asymmetry alarm not set");

    property p_alarm_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (alarm_ff && !clear_i) |=> alarm_ff;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("asymmetry alarm dropped without clear");

endmodule : rsf_asym_mon

// File: hw/rsf_monitor.sv
`timescale 1ns/1ps

module rsf_monitor
    import rsf_pkg::*;
(
    input  wire logic                             clk_i,
    input  wire logic                             nrst_i,
    input  wire rsf_switch_t                      switch_i,
    input  wire rsf_pos_t     [`RSF_NUM_RODS-1:0] rod_abs_pos_i,
    input  wire rsf_pos_t     [`RSF_NUM_RODS-1:0] rod_rel_pos_i,
    input  wire rsf_grp_t     [`RSF_NUM_RODS-1:0] rod_grp_i,
    input  wire logic         [`RSF_NUM_RODS-1:0] rod_out_lim_i,
    input  wire logic         [`RSF_NUM_RODS-1:0] rod_in_lim_i,
    input  wire logic         [`RSF_NUM_RODS-1:0] rod_xfer_i,
    output logic              [`RSF_NUM_GRP-1:0]  grp_wd_en_o,
    output logic              [`RSF_NUM_GRP-1:0]  grp_ins_en_o,
    output rsf_grp_ind_t      [`RSF_NUM_GRP-1:0]  grp_ind_o,
    output rsf_rod_ind_t      [`RSF_NUM_RODS-1:0] rod_ind_o,
    output rsf_pos_t          [`RSF_NUM_RODS-1:0] rod_disp_o,
    output rsf_pos_t          [`RSF_NUM_METERS-1:0] meter_o,
    output rsf_alarm_t                            alarm_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Operator switches and power signal come from pins
    logic [`RSF_NUM_SW-1:0] sync1_ff;
    logic [`RSF_NUM_SW-1:0] sync2_ff;
    logic [`RSF_NUM_SW-1:0] sync3_ff;
    logic [`RSF_NUM_SW-1:0] sw_ff;
    rsf_switch_t            sw;
    logic                   clr_prev_ff;
    logic                   clr_pulse;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            sw_ff    <= '0;
        end else begin
            sync1_ff <= switch_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            // Take a change only once two stages agree
            sw_ff    <= (sync2_ff & sync3_ff)
                      | (sw_ff & (sync2_ff ^ sync3_ff));
        end
    end

    assign sw = rsf_switch_t'(sw_ff);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clr_prev_ff <= 1'b0;
        end else begin
            clr_prev_ff <= sw.fault_clear;
        end
    end

    // Held button clears once, not every cycle
    assign clr_pulse = sw.fault_clear & ~clr_prev_ff;

    // Group sums, counts and limit summaries
    logic [`RSF_SUM_W-1:0] abs_sum [`RSF_NUM_GRP];
    logic [`RSF_SUM_W-1:0] rel_sum [`RSF_NUM_GRP];
    logic [`RSF_CNT_W-1:0] cnt     [`RSF_NUM_GRP];
    logic [`RSF_NUM_GRP-1:0] grp_out_c;
    logic [`RSF_NUM_GRP-1:0] grp_in_c;
    logic [`RSF_NUM_GRP-1:0] grp_xfer_c;

    always_comb begin
        grp_out_c  = '1;
        grp_in_c   = '1;
        grp_xfer_c = '0;
        for (int g = 0; g < `RSF_NUM_GRP; g++) begin
            abs_sum[g] = '0;
            rel_sum[g] = '0;
            cnt[g]     = '0;
        end
        for (int r = 0; r < `RSF_NUM_RODS; r++) begin
            abs_sum[rod_grp_i[r]] = abs_sum[rod_grp_i[r]]
                                  + `RSF_SUM_W'(rod_abs_pos_i[r]);
            rel_sum[rod_grp_i[r]] = rel_sum[rod_grp_i[r]]
                                  + `RSF_SUM_W'(rod_rel_pos_i[r]);
            cnt[rod_grp_i[r]] = cnt[rod_grp_i[r]] + `RSF_CNT_W'(1);
            if (!rod_out_lim_i[r]) begin
                grp_out_c[rod_grp_i[r]] = 1'b0;
            end
            if (!rod_in_lim_i[r]) begin
                grp_in_c[rod_grp_i[r]] = 1'b0;
            end
            if (rod_xfer_i[r]) begin
                grp_xfer_c[rod_grp_i[r]] = 1'b1;
            end
        end
        // An empty group shows no limit
        for (int g = 0; g < `RSF_NUM_GRP; g++) begin
            if (cnt[g] == '0) begin
                grp_out_c[g] = 1'b0;
                grp_in_c[g]  = 1'b0;
            end
        end
    end

    rsf_pos_t                avg_abs_ff [`RSF_NUM_GRP];
    rsf_pos_t                avg_rel_ff [`RSF_NUM_GRP];
    logic [`RSF_NUM_GRP-1:0] grp_out_ff;
    logic [`RSF_NUM_GRP-1:0] grp_in_ff;
    logic [`RSF_NUM_GRP-1:0] grp_xfer_ff;
    rsf_pos_t                rod_pos_ff [`RSF_NUM_RODS];
    logic                    live_ff;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int g = 0; g < `RSF_NUM_GRP; g++) begin
                avg_abs_ff[g] <= `RSF_POS_RST;
                avg_rel_ff[g] <= `RSF_POS_RST;
            end
        end else begin
            for (int g = 0; g < `RSF_NUM_GRP; g++) begin
                if (cnt[g] == '0) begin
                    avg_abs_ff[g] <= `RSF_POS_RST;
                    avg_rel_ff[g] <= `RSF_POS_RST;
                end else begin
                    avg_abs_ff[g] <= `RSF_POS_W'(abs_sum[g]
                                   / `RSF_SUM_W'(cnt[g]));
                    avg_rel_ff[g] <= `RSF_POS_W'(rel_sum[g]
                                   / `RSF_SUM_W'(cnt[g]));
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            grp_out_ff  <= '0;
            grp_in_ff   <= '0;
            grp_xfer_ff <= '0;
        end else begin
            grp_out_ff  <= grp_out_c;
            grp_in_ff   <= grp_in_c;
            grp_xfer_ff <= grp_xfer_c;
        end
    end

    // Rod sample moves with the group average, so a
    // group in motion never shows a one-cycle false asymmetry
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int r = 0; r < `RSF_NUM_RODS; r++) begin
                rod_pos_ff[r] <= `RSF_POS_RST;
            end
        end else begin
            for (int r = 0; r < `RSF_NUM_RODS; r++) begin
                rod_pos_ff[r] <= rod_abs_pos_i[r];
            end
        end
    end

    // Summaries are stale at the first edge after reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
        end
    end

    // Threshold detectors, one per regulating group
    logic [`RSF_NUM_REG-1:0] hi_abs;
    logic [`RSF_NUM_REG-1:0] lo_abs;
    logic [`RSF_NUM_REG-1:0] hi_rel;
    logic [`RSF_NUM_REG-1:0] lo_rel;

    always_comb begin
        for (int i = 0; i < `RSF_NUM_REG; i++) begin
            hi_abs[i] = avg_abs_ff[i + `RSF_REG_BASE] > `RSF_SEQ_HI_SP;
            lo_abs[i] = !(avg_abs_ff[i + `RSF_REG_BASE] > `RSF_SEQ_LO_SP);
            hi_rel[i] = avg_rel_ff[i + `RSF_REG_BASE] > `RSF_SEQ_HI_SP;
            lo_rel[i] = !(avg_rel_ff[i + `RSF_REG_BASE] > `RSF_SEQ_LO_SP);
        end
    end

    logic auto_ff;
    logic seq_fault_ff;
    logic asym_fault_ff;
    logic out_inhibit_ff;
    logic safety_alarm_ff;
    logic safety_out;
    logic bypass_act;
    logic seq_cond;
    logic seq_set;

    assign safety_out = &grp_out_ff[`RSF_NUM_SAFETY-1:0];
    assign bypass_act = !auto_ff & sw.bypass_sel;

    assign seq_cond =
        (!lo_rel[1] & !hi_rel[0])
      | (!lo_rel[2] & !(hi_rel[1] & grp_out_ff[`RSF_G5]))
      | (!safety_out & !(&grp_in_ff[`RSF_G7:`RSF_G5]));
    assign seq_set = seq_cond & !bypass_act & live_ff;

    // Per-rod asymmetry monitors
    logic [`RSF_NUM_RODS-1:0] rod_alarm;
    logic [`RSF_NUM_RODS-1:0] rod_fault;

    for (genvar r = 0; r < `RSF_NUM_RODS; r++) begin : g_rod
        rsf_asym_mon u_mon (
            .clk_i     (clk_i),
            .nrst_i    (nrst_i),
            .rod_pos_i (rod_pos_ff[r]),
            .grp_avg_i (avg_abs_ff[rod_grp_i[r]]),
            .clear_i   (clr_pulse),
            .alarm_o   (rod_alarm[r]),
            .fault_o   (rod_fault[r])
        );
    end

    // auto mode drops on sequence fault
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            auto_ff <= 1'b0;
        end else begin
            auto_ff <= sw.auto_sel & !seq_fault_ff & !seq_set;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seq_fault_ff    <= 1'b0;
            asym_fault_ff   <= 1'b0;
            out_inhibit_ff  <= 1'b0;
            safety_alarm_ff <= 1'b0;
        end else begin
            if (seq_set) begin
                seq_fault_ff <= 1'b1;
            end else if (clr_pulse && !seq_cond) begin
                seq_fault_ff <= 1'b0;
            end
            if (|rod_fault) begin
                asym_fault_ff <= 1'b1;
            end else if (clr_pulse) begin
                asym_fault_ff <= 1'b0;
            end
            // withdraw block, mode and power only
            if (|rod_fault && auto_ff && sw.pwr_above_60) begin
                out_inhibit_ff <= 1'b1;
            end else if (clr_pulse && !(|rod_fault)) begin
                out_inhibit_ff <= 1'b0;
            end
            if (!safety_out && live_ff) begin
                safety_alarm_ff <= 1'b1;
            end else if (clr_pulse) begin
                safety_alarm_ff <= 1'b0;
            end
        end
    end

    logic [`RSF_NUM_GRP-1:0] nxt_wd_en;
    logic [`RSF_NUM_GRP-1:0] nxt_ins_en;
    logic [`RSF_NUM_GRP-1:0] wd_en_ff;
    logic [`RSF_NUM_GRP-1:0] ins_en_ff;

    always_comb begin
        nxt_wd_en  = '1;
        nxt_ins_en = '1;
        nxt_wd_en[`RSF_G5]  = safety_out;
        nxt_wd_en[`RSF_G6]  = safety_out & (bypass_act | hi_abs[0]);
        nxt_wd_en[`RSF_G7]  = safety_out
                            & (bypass_act
                               | (hi_abs[1] & grp_out_ff[`RSF_G5]));
        nxt_ins_en[`RSF_G6] = bypass_act | lo_abs[2];
        nxt_ins_en[`RSF_G5] = bypass_act | lo_abs[1];
        // out command blocked on all groups
        if (out_inhibit_ff) begin
            nxt_wd_en = '0;
        end
        nxt_wd_en  = nxt_wd_en & ~grp_xfer_ff;
        nxt_ins_en = nxt_ins_en & ~grp_xfer_ff;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wd_en_ff  <= '0;
            ins_en_ff <= '0;
        end else begin
            wd_en_ff  <= nxt_wd_en;
            ins_en_ff <= nxt_ins_en;
        end
    end

    // Indicators and displays
    rsf_rod_ind_t [`RSF_NUM_RODS-1:0]   rod_ind_ff;
    rsf_pos_t     [`RSF_NUM_RODS-1:0]   rod_disp_ff;
    rsf_pos_t     [`RSF_NUM_METERS-1:0] meter_ff;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rod_ind_ff  <= '0;
            rod_disp_ff <= '0;
        end else begin
            for (int r = 0; r < `RSF_NUM_RODS; r++) begin
                rod_ind_ff[r] <= '{full_out: rod_out_lim_i[r],
                                   full_in:  rod_in_lim_i[r],
                                   enabled:  wd_en_ff[rod_grp_i[r]]
                                           | ins_en_ff[rod_grp_i[r]],
                                   xfer:     rod_xfer_i[r],
                                   asym:     rod_alarm[r]};
                rod_disp_ff[r] <= sw.rel_disp_sel ? rod_rel_pos_i[r]
                                                  : rod_abs_pos_i[r];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meter_ff <= '0;
        end else begin
            for (int i = 0; i < `RSF_NUM_METERS; i++) begin
                meter_ff[i] <= sw.meter_hi_sel
                             ? avg_abs_ff[i + `RSF_NUM_METERS]
                             : avg_abs_ff[i];
            end
        end
    end

    always_comb begin
        for (int g = 0; g < `RSF_NUM_GRP; g++) begin
            grp_ind_o[g] = '{full_in:  grp_in_ff[g],
                             full_out: grp_out_ff[g],
                             enabled:  wd_en_ff[g] | ins_en_ff[g]};
        end
    end

    assign grp_wd_en_o  = wd_en_ff;
    assign grp_ins_en_o = ins_en_ff;
    assign rod_ind_o    = rod_ind_ff;
    assign rod_disp_o   = rod_disp_ff;
    assign meter_o      = meter_ff;
    assign alarm_o = '{asym_alarm:   |rod_alarm,
                       asym_fault:   asym_fault_ff,
                       out_inhibit:  out_inhibit_ff,
                       seq_fault:    seq_fault_ff,
                       safety_alarm: safety_alarm_ff,
                       bypass_ind:   bypass_act,
                       aux_permit:   bypass_act,
                       auto_mode:    auto_ff};

    sequence s_seq_latched;
        seq_fault_ff && !clr_pulse;
    endsequence

    property p_seq_drop;
        (auto_ff && seq_set) |=> (!auto_ff && seq_fault_ff);
    endproperty
    a_seq_drop: assert property (p_seq_drop)
        else $error("auto mode kept after sequence fault");

    property p_seq_stay;
        s_seq_latched |=> (!auto_ff && seq_fault_ff);
    endproperty
    a_seq_stay: assert property (p_seq_stay)
        else $error("left manual before operator reset");

    property p_inh_cause;
        $rose(out_inhibit_ff) |->
            $past(auto_ff && sw.pwr_above_60 && (|rod_fault));
    endproperty
    a_inh_cause: assert property (p_inh_cause)
        else $error("withdraw block without cause");

    property p_inh_block;
        out_inhibit_ff |=> (wd_en_ff == '0);
    endproperty
    a_inh_block: assert property (p_inh_block)
        else $error("withdraw enabled under block");

    property p_safety_hold;
        !safety_out |=> (wd_en_ff[`RSF_G7:`RSF_G5] == '0);
    endproperty
    a_safety_hold: assert property (p_safety_hold)
        else $error("regulating withdraw before safety out");

    property p_g7_order;
        wd_en_ff[`RSF_G7] |->
            $past(bypass_act || (hi_abs[1] && grp_out_ff[`RSF_G5]));
    endproperty
    a_g7_order: assert property (p_g7_order)
        else $error("group 7 withdraw out of order");

    property p_xfer;
        (|grp_xfer_ff) |=>
            (((wd_en_ff | ins_en_ff) & $past(grp_xfer_ff)) == '0);
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("transferred group still enabled");

endmodule : rsf_monitor

// File: tb/rsf_panel_model.sv
`timescale 1ns/1ps

module rsf_panel_model
    import rsf_pkg::*;
(
    input  wire logic  auto_i,
    input  wire logic  bypass_i,
    input  wire logic  clear_i,
    input  wire logic  pwr_i,
    input  wire logic  rel_i,
    input  wire logic  hi_i,
    output rsf_switch_t switch_o
);
    assign switch_o = {auto_i, bypass_i, clear_i, pwr_i, rel_i, hi_i};
endmodule : rsf_panel_model

// File: tb/rsf_monitor_tb.sv
`timescale 1ns/1ps

module rsf_monitor_tb
    import rsf_pkg::*;
;
    logic                   clk_i  = 1'b0;
    logic                   nrst_i = 1'b0;
    logic                   auto, bypass, clr, pwr, rel, hi;
    rsf_switch_t            sw;
    rsf_pos_t     [60:0]    abs_p, rel_p, disp;
    rsf_grp_t     [60:0]    grp;
    logic         [60:0]    olim, ilim, xfer;
    logic         [7:0]     wd, ins;
    rsf_grp_ind_t [7:0]     gind;
    rsf_rod_ind_t [60:0]    rind;
    rsf_pos_t     [3:0]     meter;
    rsf_alarm_t             alm;
    int                     n_errors = 0;
    int                     n_tests  = 0;
    int                     seed     = 12;
    int                     gpos[8];
    int                     xg[8];
    int                     dpos, df, a, f, inh;
    int                     tab[8][3] = '{'{103,0,0}, '{104,0,0},
        '{139,103,0}, '{139,104,0}, '{139,104,36}, '{139,104,35},
        '{139,36,0}, '{139,35,0}};
    int                     asy[5][3] = '{'{1,1,8}, '{1,1,9}, '{1,1,11},
        '{0,1,-12}, '{1,0,-12}};

    always #2 clk_i = ~clk_i;

    rsf_panel_model u_panel (.auto_i(auto), .bypass_i(bypass), .clear_i(clr),
        .pwr_i(pwr), .rel_i(rel), .hi_i(hi), .switch_o(sw));

    rsf_monitor u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .switch_i(sw),
        .rod_abs_pos_i(abs_p), .rod_rel_pos_i(rel_p), .rod_grp_i(grp),
        .rod_out_lim_i(olim), .rod_in_lim_i(ilim), .rod_xfer_i(xfer),
        .grp_wd_en_o(wd), .grp_ins_en_o(ins), .grp_ind_o(gind),
        .rod_ind_o(rind), .rod_disp_o(disp), .meter_o(meter),
        .alarm_o(alm));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chk1

    function automatic int mpos(input int i);
        return (i == 7) ? dpos : gpos[i % 8];
    endfunction : mpos

    function automatic int avg(input int g);
        int s;
        int c;
        s = 0;
        c = 0;
        for (int i = 0; i < 61; i++) begin
            if (i % 8 == g) begin
                s += mpos(i);
                c++;
            end
        end
        return (c == 0) ? 0 : s / c;
    endfunction : avg

    task automatic apply();
        for (int i = 0; i < 61; i++) begin
            abs_p[i] = rsf_pos_t'(mpos(i));
            rel_p[i] = rsf_pos_t'(mpos(i) - ((i % 8 == 7) ? 1 : 0));
            grp[i]   = rsf_grp_t'(i % 8);
            olim[i]  = (mpos(i) == 139);
            ilim[i]  = (mpos(i) == 0);
            xfer[i]  = (xg[i % 8] != 0);
        end
    endtask : apply

    task automatic check_en(input int blk);
        logic [7:0] ew;
        logic [7:0] ei;
        ew = 8'hff;
        ei = 8'hff;
        ew[5] = avg(4) > 103;
        ew[6] = (avg(5) > 103) && (gpos[4] == 139);
        ei[4] = avg(5) <= 35;
        ei[5] = avg(6) <= 35;
        for (int g = 0; g < 8; g++) begin
            if (xg[g] != 0) begin
                ew[g] = 1'b0;
                ei[g] = 1'b0;
            end
        end
        chk(wd, (blk != 0) ? 8'h00 : ew);
        chk(ins, ei);
    endtask : check_en

    task automatic pulse();
        clr = 1'b1;
        cyc(8);
        clr = 1'b0;
        cyc(8);
    endtask : pulse

    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    initial begin
        {auto, bypass, clr, pwr, rel, hi} = 6'h00;
        foreach (gpos[g]) begin
            gpos[g] = 0;
            xg[g]   = 0;
        end
        gpos[7] = 20 + ({$random(seed)} % 100);
        dpos = gpos[7];
        apply();
        cyc(12);
        chk(alm, 8'h00);
        chk(wd, 8'h00);
        nrst_i = 1'b1;
        cyc(8);
        chk1(alm.safety_alarm, 1'b1);
        chk1(wd[4], 1'b0);
        for (int g = 0; g < 4; g++) gpos[g] = 139;
        apply();
        cyc(8);
        pulse();
        chk1(alm.safety_alarm, 1'b0);
        for (int r = 0; r < 8; r++) begin
            for (int k = 0; k < 3; k++) gpos[4 + k] = tab[r][k];
            apply();
            cyc(8);
            check_en(0);
        end
        chk1(gind[0].full_out, 1'b1);
        chk1(gind[4].enabled, 1'b1);
        chk1(gind[6].full_in, 1'b1);
        chk1(rind[4].full_out, 1'b1);
        chk1(rind[6].full_in, 1'b1);
        chk1(rind[5].enabled, 1'b1);
        xg[5] = 1;
        apply();
        cyc(8);
        check_en(0);
        chk1(rind[5].xfer, 1'b1);
        xg[5] = 0;
        apply();
        for (int h = 0; h < 2; h++) begin
            hi = h[0];
            cyc(8);
            for (int k = 0; k < 4; k++) begin
                chk(meter[k], rsf_pos_t'(avg(k + 4 * h)));
            end
        end
        for (int r = 0; r < 2; r++) begin
            rel = r[0];
            cyc(8);
            chk(disp[7], rsf_pos_t'(mpos(7) - r));
        end
        for (int r = 0; r < 5; r++) begin
            auto = asy[r][0][0];
            pwr  = asy[r][1][0];
            cyc(8);
            chk1(alm.auto_mode, auto);
            dpos = gpos[7] + asy[r][2];
            apply();
            cyc(8);
            df  = (dpos > avg(7)) ? dpos - avg(7) : avg(7) - dpos;
            a   = df > 7;
            f   = df > 9;
            inh = f && asy[r][0] && asy[r][1];
            chk1(rind[7].asym, a[0]);
            chk1(alm.asym_alarm, a[0]);
            chk1(alm.asym_fault, f[0]);
            chk1(alm.out_inhibit, inh[0]);
            check_en(inh);
            dpos = gpos[7];
            apply();
            cyc(8);
            chk1(alm.asym_fault, f[0]);
            pulse();
            chk1(alm.asym_fault, 1'b0);
            chk1(rind[7].asym, 1'b0);
        end
        gpos[4] = 0;
        gpos[5] = 40;
        apply();
        cyc(8);
        chk1(alm.seq_fault, 1'b1);
        chk1(alm.auto_mode, 1'b0);
        gpos[5] = 0;
        apply();
        cyc(8);
        chk1(alm.auto_mode, 1'b0);
        pulse();
        chk1(alm.auto_mode, 1'b1);
        // Bypass must be in force before the groups leave sequence
        auto = 1'b0;
        bypass = 1'b1;
        cyc(8);
        gpos[5] = 40;
        apply();
        cyc(8);
        chk1(alm.bypass_ind, 1'b1);
        chk1(alm.aux_permit, 1'b1);
        chk1(alm.seq_fault, 1'b0);
        bypass = 1'b0;
        cyc(8);
        chk1(alm.bypass_ind, 1'b0);
        chk1(alm.aux_permit, 1'b0);
        chk1(alm.seq_fault, 1'b1);
        give_verdict();
    end
endmodule : rsf_monitor_tb
